// ===== common/afps_defines.vh
// Constants for the arc flash protection stage: offsets, fields, timing.
`ifndef AFPS_DEFINES_VH
`define AFPS_DEFINES_VH

// Register offsets, byte addresses on an 8-bit address port.
`define AFPS_REG_CTRL        8'h00
`define AFPS_REG_PASSWORD    8'h04
`define AFPS_REG_SRC_SEL     8'h08
`define AFPS_REG_DELAY       8'h0C
`define AFPS_REG_PICKUP_PH   8'h10
`define AFPS_REG_PICKUP_R1   8'h14
`define AFPS_REG_PICKUP_R2   8'h18
`define AFPS_REG_ROUTE       8'h1C
`define AFPS_REG_STATUS      8'h20
`define AFPS_REG_FORCE_STAT  8'h24
`define AFPS_REG_LIGHT_CNT   8'h28
`define AFPS_REG_START_CNT0  8'h2C
`define AFPS_REG_TRIP_CNT0   8'h38

// Control register fields.
`define AFPS_CTRL_FORCE      0
`define AFPS_CTRL_CLEAR      1
`define AFPS_CTRL_LOCK       2

// Password value that unlocks settings; arbitrary value.
`define AFPS_PASSWORD        32'h0000A5C3

// Light source selection codes: bit0 sensor 1, bit1 sensor 2, bit2 input.
`define AFPS_SEL_S1          0
`define AFPS_SEL_S2          1
`define AFPS_SEL_IN          2

// Routing selector codes for the peer light output.
`define AFPS_ROUTE_S1        3'h1
`define AFPS_ROUTE_S2        3'h2
`define AFPS_ROUTE_BOTH      3'h3
`define AFPS_ROUTE_IN        3'h4
`define AFPS_ROUTE_DLY       3'h5
`define AFPS_ROUTE_TRIP      3'h6

// Timing: delay held in units of 10 ms, range 1 to 15.
`define AFPS_CLK_HZ          125000000
`define AFPS_DLY_UNIT_MS     10
`define AFPS_TICK_CYCLES     ((`AFPS_CLK_HZ / 1000) * `AFPS_DLY_UNIT_MS)
`define AFPS_DLY_MIN         4'h1
`define AFPS_DLY_MAX         4'hF
`define AFPS_FORCE_TIMEOUT_MIN 5
`define AFPS_FORCE_TICKS     (`AFPS_FORCE_TIMEOUT_MIN * 60 * 100)

// Reset values.
`define AFPS_RST_DELAY       4'h1
`define AFPS_RST_PICKUP      16'h0100

`endif

// ===== hw/afps_top.v
// Arc flash protection stage: three light+current stages, delayed light.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "afps_defines.vh"
// Notes on behaviour
// - Two independent light sensor channels.
// - Peer output driven by sensors or input.
// - Peer output source chosen only by routing.
// - Peer input state routable to destinations.
// - Delayed light, delay 0.01 s to 0.15 s.
// - Delayed light is a routing source.
// - Start reported when selected light seen.
// - Trip needs light and current over pickup.
// - Phase pickup per unit, versus maximum phase current.
// - Residual pickups scaled per own input.
// - Stage source selection has eight codes.
// - Delayed light has own eight-code selection.
// - Delay held in own setting of 10 ms steps.
// - Light counter counts any light source.
// - Per-stage start and trip counters.
// - All counters clearable on command.
// - Shared force flag clears after five minutes.
// - Status writable only while force set.
// - Settings writable only after password.
module afps_top (
    // Clock, reset and enable.
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // Register port.
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // Pins from sensors and peer relay.
    input  wire        light_sensor_one_i,
    input  wire        light_sensor_two_i,
    input  wire        peer_light_input_i,
    // Currents in per unit, 8.8 fixed point, same clock domain.
    input  wire [15:0] max_phase_current_i,
    input  wire [15:0] residual1_current_i,
    input  wire [15:0] residual2_current_i,
    // Results.
    output reg         peer_light_output_o,
    output reg  [2:0]  stage_start_o,
    output reg  [2:0]  stage_trip_o,
    output reg         delayed_light_o,
    output reg         peer_input_state_o
);

    // Pins are asynchronous levels. A change reaches the decisions two
    // enabled edges later and the outputs one edge after that.
    // Pulses shorter than a clock may be missed; sensors hold far longer.

    // Two-flop synchronisers for the three pins.
    reg [2:0]  pin_meta_reg;
    reg [2:0]  pin_sync_reg;
    wire [2:0] pins = {peer_light_input_i, light_sensor_two_i,
                       light_sensor_one_i};

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else if (ce_i) begin
            pin_meta_reg <= pins;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // One enable gates every register below, so a low enable
    // freezes the whole stage, its test timers included.

    // Settings and control state.
    reg        unlocked_reg;
    reg        force_reg;
    reg [8:0]  stage_sel_reg;   // Three 3-bit source codes.
    reg [2:0]  delayed_light_source_sel_reg;
    reg [3:0]  delay_reg;
    reg [15:0] pickup_reg [0:2];
    reg [2:0]  route_reg;
    reg [2:0]  forced_start_reg;
    reg [2:0]  forced_trip_reg;
    reg        clear_reg;
    reg [31:0] light_event_count_reg;
    reg [31:0] stage_start_count_reg [0:2];
    reg [31:0] stage_trip_count_reg [0:2];
    reg [23:0] tick_cnt_reg;
    reg [23:0] dly_phase_reg;
    reg [15:0] force_ticks_reg;
    reg [3:0]  dly_cnt_reg;
    reg [2:0]  start_prev_reg;
    reg [2:0]  trip_prev_reg;
    reg        any_light_prev_reg;
    integer    i;

    // Password, relock, clear and forced status writes bypass this gate; every other
    // setting write, the force bit included, must pass it.

    // A setting write is honoured only while unlocked.
    wire set_wr = wr_i && unlocked_reg;

    // Trip compares strictly above the pickup, so a current that
    // sits exactly at the setting does not trip.

    // Per-stage light and current decisions.
    reg [2:0] light_hit;
    reg [2:0] over_pickup;
    reg [2:0] start_now;
    reg [2:0] trip_now;
    reg [2:0] sel;
    reg [15:0] cur;

    always @* begin
        sel = 3'h0;
        cur = 16'h0000;
        for (i = 0; i < 3; i = i + 1) begin
            sel = stage_sel_reg[i*3 +: 3];
            // Each code bit enables one source; eight codes total.
            light_hit[i] = |(sel & pin_sync_reg);
            case (i)
                0: cur = max_phase_current_i;
                1: cur = residual1_current_i;
                default: cur = residual2_current_i;
            endcase
            over_pickup[i] = cur > pickup_reg[i];
        end
        // Forced values replace live ones during test.
        start_now = force_reg ? forced_start_reg : light_hit;
        trip_now  = force_reg ? forced_trip_reg
                              : (light_hit & over_pickup);
    end

    // Delayed light: any selected source lit, same codes as the stages.
    wire dly_cond  = |(delayed_light_source_sel_reg
                       & pin_sync_reg);
    wire any_light = |pin_sync_reg;

    // Free-running 10 ms tick for the force timeout. It is never held
    // by the light condition, or force would not expire in the dark.
    wire tick      = (tick_cnt_reg == `AFPS_TICK_CYCLES - 1);

    // The delay tick has its own phase, restarted at condition onset,
    // so the first delay step is always a whole tick long.
    wire dly_tick  = (dly_phase_reg == `AFPS_TICK_CYCLES - 1);

    always @(posedge clk_i) begin
        if (rst_i) begin
            dly_phase_reg <= 24'h000000;
        end else if (ce_i) begin
            if (!dly_cond || dly_tick)
                dly_phase_reg <= 24'h000000;
            else
                dly_phase_reg <= dly_phase_reg + 24'h000001;
        end
    end

    // Unused codes drive the output low rather than hold it.

    // Routing of the peer output; only the selector decides.
    reg route_val;
    always @* begin
        case (route_reg)
            `AFPS_ROUTE_S1:   route_val = pin_sync_reg[0];
            `AFPS_ROUTE_S2:   route_val = pin_sync_reg[1];
            `AFPS_ROUTE_BOTH: route_val = pin_sync_reg[0] | pin_sync_reg[1];
            `AFPS_ROUTE_IN:   route_val = pin_sync_reg[2];
            `AFPS_ROUTE_DLY:  route_val = delayed_light_o;
            `AFPS_ROUTE_TRIP: route_val = |stage_trip_o;
            default:          route_val = 1'b0;
        endcase
    end

    // Writes land at the edge that samples the strobe, so a read in
    // the very next cycle already returns the new value.

    // Register writes, force timeout and delay timer.
    always @(posedge clk_i) begin
        if (rst_i) begin
            unlocked_reg <= 1'b0;
            force_reg <= 1'b0;
            stage_sel_reg <= 9'h000;
            delayed_light_source_sel_reg <= 3'h0;
            delay_reg <= `AFPS_RST_DELAY;
            for (i = 0; i < 3; i = i + 1)
                pickup_reg[i] <= `AFPS_RST_PICKUP;
            route_reg <= 3'h0;
            forced_start_reg <= 3'h0;
            forced_trip_reg <= 3'h0;
            clear_reg <= 1'b0;
            tick_cnt_reg <= 24'h000000;
            force_ticks_reg <= 16'h0000;
            dly_cnt_reg <= 4'h0;
            delayed_light_o <= 1'b0;
        end else if (ce_i) begin
            clear_reg <= 1'b0;
            tick_cnt_reg <= tick ? 24'h000000 : tick_cnt_reg + 24'h000001;
            // Password register unlocks, control lock bit relocks.
            if (wr_i && addr_i == `AFPS_REG_PASSWORD)
                unlocked_reg <= (wdata_i == `AFPS_PASSWORD);
            if (wr_i && addr_i == `AFPS_REG_CTRL) begin
                clear_reg <= wdata_i[`AFPS_CTRL_CLEAR];
                if (wdata_i[`AFPS_CTRL_LOCK])
                    unlocked_reg <= 1'b0;
            end
            // A new force write restarts the five minutes; an authorised
            // write of zero drops the flag early.
            // Force flag: set by authorised write, self-clears on timeout.
            if (set_wr && addr_i == `AFPS_REG_CTRL) begin
                force_reg <= wdata_i[`AFPS_CTRL_FORCE];
                force_ticks_reg <= 16'h0000;
            end else if (force_reg && tick) begin
                if (force_ticks_reg == `AFPS_FORCE_TICKS - 1)
                    force_reg <= 1'b0;
                force_ticks_reg <= force_ticks_reg + 16'h0001;
            end
            if (set_wr) begin
                case (addr_i)
                    `AFPS_REG_SRC_SEL: begin
                        stage_sel_reg <= wdata_i[8:0];
                        delayed_light_source_sel_reg <= wdata_i[18:16];
                    end
                    `AFPS_REG_DELAY: begin
                        // Only bits 3:0 are taken; a delay of zero is raised to the minimum of 1.
                        if (wdata_i[3:0] < `AFPS_DLY_MIN)
                            delay_reg <= `AFPS_DLY_MIN;
                        else
                            delay_reg <= wdata_i[3:0];
                    end
                    `AFPS_REG_PICKUP_PH: pickup_reg[0] <= wdata_i[15:0];
                    `AFPS_REG_PICKUP_R1: pickup_reg[1] <= wdata_i[15:0];
                    `AFPS_REG_PICKUP_R2: pickup_reg[2] <= wdata_i[15:0];
                    `AFPS_REG_ROUTE:     route_reg <= wdata_i[2:0];
                    default: ;
                endcase
            end
            // Forced status only writable while force is on.
            if (wr_i && force_reg && addr_i == `AFPS_REG_FORCE_STAT) begin
                forced_start_reg <= wdata_i[2:0];
                forced_trip_reg  <= wdata_i[6:4];
            end
            // The output drops one edge after the condition clears,
            // without waiting for a tick.
            // Delay timer restarts whenever the condition drops.
            if (!dly_cond) begin
                dly_cnt_reg <= 4'h0;
                delayed_light_o <= 1'b0;
            end else if (dly_tick && !delayed_light_o) begin
                if (dly_cnt_reg + 4'h1 >= delay_reg)
                    delayed_light_o <= 1'b1;
                dly_cnt_reg <= dly_cnt_reg + 4'h1;
            end
        end
    end

    // Edges come from the values that drive the outputs, so forced
    // status during a test counts like a real event.
    // The clear pulse lasts one enabled cycle only.

    // Counters count rising edges; clear wins only without an edge.
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_prev_reg <= 3'h0;
            trip_prev_reg <= 3'h0;
            any_light_prev_reg <= 1'b0;
            light_event_count_reg <= 32'h00000000;
            for (i = 0; i < 3; i = i + 1) begin
                stage_start_count_reg[i] <= 32'h00000000;
                stage_trip_count_reg[i] <= 32'h00000000;
            end
        end else if (ce_i) begin
            start_prev_reg <= start_now;
            trip_prev_reg <= trip_now;
            any_light_prev_reg <= any_light;
            if (any_light && !any_light_prev_reg)
                light_event_count_reg <= clear_reg ? 32'h00000001
                                       : light_event_count_reg + 32'h1;
            else if (clear_reg)
                light_event_count_reg <= 32'h00000000;
            for (i = 0; i < 3; i = i + 1) begin
                if (start_now[i] && !start_prev_reg[i])
                    stage_start_count_reg[i] <= clear_reg ? 32'h00000001
                        : stage_start_count_reg[i] + 32'h1;
                else if (clear_reg)
                    stage_start_count_reg[i] <= 32'h00000000;
                if (trip_now[i] && !trip_prev_reg[i])
                    stage_trip_count_reg[i] <= clear_reg ? 32'h00000001
                        : stage_trip_count_reg[i] + 32'h1;
                else if (clear_reg)
                    stage_trip_count_reg[i] <= 32'h00000000;
            end
        end
    end

    // Each result leaves through a flip-flop: one cycle of latency
    // buys glitch-free pins and routing.

    // Registered outputs.
    always @(posedge clk_i) begin
        if (rst_i) begin
            peer_light_output_o <= 1'b0;
            stage_start_o <= 3'h0;
            stage_trip_o <= 3'h0;
            peer_input_state_o <= 1'b0;
        end else if (ce_i) begin
            peer_light_output_o <= route_val;
            stage_start_o <= start_now;
            stage_trip_o <= trip_now;
            peer_input_state_o <= pin_sync_reg[2];
        end
    end

    // Register map, byte offsets:
    //   0x00 control: bit 0 force, bit 1 clear, bit 2 relock.
    //        Reads give bit 2 as locked, bit 0 as force.
    //   0x04 password: right word unlocks, any other locks.
    //   0x08 codes: stages in 8:0, delayed light in 18:16.
    //   0x0C delay in 10 ms steps, 1 to 15; zero reads 1.
    //   0x10, 0x14, 0x18 pickups, 8.8 per unit.
    //   0x1C routing code of the peer light output.
    //   0x20 live status, 0x24 forced status.
    //   0x28 light count, 0x2C-0x34 starts, 0x38-0x40 trips.
    // Code bits: 0 sensor one, 1 sensor two, 2 peer input.
    // Counters are 32 bits and wrap; clear them in time.
    // Reads have no side effects.

    // Read port: data in the cycle after the strobe, zero if unmapped.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            rdata_o <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                    `AFPS_REG_CTRL:
                        rdata_o <= {29'h0, ~unlocked_reg, 1'b0, force_reg};
                    `AFPS_REG_SRC_SEL:
                        rdata_o <= {13'h0, delayed_light_source_sel_reg,
                                    7'h0, stage_sel_reg};
                    `AFPS_REG_DELAY:     rdata_o <= {28'h0, delay_reg};
                    `AFPS_REG_PICKUP_PH: rdata_o <= {16'h0, pickup_reg[0]};
                    `AFPS_REG_PICKUP_R1: rdata_o <= {16'h0, pickup_reg[1]};
                    `AFPS_REG_PICKUP_R2: rdata_o <= {16'h0, pickup_reg[2]};
                    `AFPS_REG_ROUTE:     rdata_o <= {29'h0, route_reg};
                    `AFPS_REG_STATUS:
                        rdata_o <= {20'h0, delayed_light_o, pin_sync_reg,
                                    1'b0, stage_trip_o, 1'b0, stage_start_o};
                    `AFPS_REG_FORCE_STAT:
                        rdata_o <= {25'h0, forced_trip_reg, 1'b0,
                                    forced_start_reg};
                    `AFPS_REG_LIGHT_CNT: rdata_o <= light_event_count_reg;
                    8'h2C: rdata_o <= stage_start_count_reg[0];
                    8'h30: rdata_o <= stage_start_count_reg[1];
                    8'h34: rdata_o <= stage_start_count_reg[2];
                    8'h38: rdata_o <= stage_trip_count_reg[0];
                    8'h3C: rdata_o <= stage_trip_count_reg[1];
                    8'h40: rdata_o <= stage_trip_count_reg[2];
                    default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ===== bench/afps_checker.sv
// Port checker for the arc flash protection stage, bound to its top.
`timescale 1ns/100ps
`include "afps_defines.vh"
module afps_checker (
    // Clock, reset, enable and bus.
    input wire        clk_i,
    input wire        rst_i,
    input wire        ce_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    // Pins and currents.
    input wire        light_sensor_one_i,
    input wire        light_sensor_two_i,
    input wire        peer_light_input_i,
    input wire [15:0] max_phase_current_i,
    input wire [15:0] residual1_current_i,
    input wire [15:0] residual2_current_i,
    // Results.
    input wire        peer_light_output_o,
    input wire [2:0]  stage_start_o,
    input wire [2:0]  stage_trip_o,
    input wire        delayed_light_o,
    input wire        peer_input_state_o
);
    wire [2:0]  pins_w = {light_sensor_one_i, light_sensor_two_i,
                          peer_light_input_i};
    wire [51:0] in_w = {pins_w, max_phase_current_i, residual1_current_i,
                        residual2_current_i, wr_i};
    wire [41:0] outs_w = {rdata_o, stage_start_o, stage_trip_o,
                          peer_light_output_o, delayed_light_o,
                          peer_input_state_o};
    wire        run_w = ce_i && !rst_i;
    reg  [51:0] in_q;
    reg  [2:0]  dark_n;
    reg  [2:0]  calm_n;
    reg  [20:0] lit_n;

    function [2:0] sat3(input [2:0] v);
        sat3 = (v == 3'h7) ? v : v + 3'h1;
    endfunction

    // Run lengths of dark pins, quiet inputs and light; ce low holds them.
    always @(posedge clk_i) begin
        if (rst_i) begin
            in_q   <= in_w;
            dark_n <= 3'h0;
            calm_n <= 3'h0;
            lit_n  <= 21'h0;
        end else if (ce_i) begin
            in_q   <= in_w;
            dark_n <= (|pins_w) ? 3'h0 : sat3(dark_n);
            calm_n <= (in_w != in_q) ? 3'h0 : sat3(calm_n);
            lit_n  <= !(|pins_w) ? 21'h0 : (&lit_n) ? lit_n : lit_n + 21'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RDATA_IDLE:
        assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    AST_CE_FREEZE:
        assert property (!ce_i |=> $stable(outs_w))
        else $error("outputs moved while the enable was low");
    AST_PEER_STATE:
        assert property ($past(run_w, 1) && $past(run_w, 2) && $past(run_w, 3)
            |-> peer_input_state_o == $past(peer_light_input_i, 3))
        else $error("peer input state does not follow its pin");
    AST_DARK_START:
        assert property (dark_n >= 3'h4 |-> stage_start_o == 3'h0)
        else $error("stage start without any light");
    AST_TRIP_START:
        assert property ((stage_trip_o & ~stage_start_o) == 3'h0)
        else $error("stage trip without its start");
    AST_PEER_DARK:
        assert property (dark_n == 3'h7 |-> !peer_light_output_o)
        else $error("peer output high with all pins dark");
    AST_CAUSED:
        assert property ($changed(stage_start_o) || $changed(stage_trip_o)
            |-> calm_n < 3'h5)
        else $error("stage status moved with no cause");
    AST_DELAY_MIN:
        assert property ($rose(delayed_light_o)
            |-> lit_n >= `AFPS_TICK_CYCLES)
        else $error("delayed light came before one delay step");

    cover property (stage_trip_o == 3'h3);
    cover property ($fell(ce_i));
    cover property (peer_light_output_o && stage_trip_o[0]);
endmodule

bind afps_top afps_checker chk_u (
    .clk_i, .rst_i, .ce_i, .wr_i, .rd_i, .rdata_o,
    .light_sensor_one_i, .light_sensor_two_i, .peer_light_input_i,
    .max_phase_current_i, .residual1_current_i, .residual2_current_i,
    .peer_light_output_o, .stage_start_o, .stage_trip_o,
    .delayed_light_o, .peer_input_state_o
);

// ===== bench/afps_light_src.sv
// Model of the two arc light sensors and the peer relay's light link.
`timescale 1ns/100ps
module afps_light_src (
    // Clock and requested light.
    input  wire       clk_i,
    input  wire [2:0] light_req_i,
    input  wire       slow_i,
    // Pins towards the relay.
    output reg        light_sensor_one_o,
    output reg        light_sensor_two_o,
    output reg        peer_light_input_o
);
    reg [2:0] lag_reg = 3'h0;

    // Dark from time zero, and a slow source lags one cycle more.
    initial
        {peer_light_input_o, light_sensor_two_o, light_sensor_one_o} = 3'h0;
    always @(posedge clk_i) begin
        lag_reg <= light_req_i;
        {peer_light_input_o, light_sensor_two_o, light_sensor_one_o} <=
            slow_i ? lag_reg : light_req_i;
    end
endmodule

// ===== bench/afps_top_bench.sv
// Self-checking bench for the arc flash protection stage.
`timescale 1ns/100ps
`include "afps_defines.vh"
module afps_top_bench;
    reg         clk_i;
    reg         rst_i;
    reg         ce_i;
    reg  [7:0]  addr_i;
    reg  [31:0] wdata_i;
    reg         wr_i;
    reg         rd_i;
    reg  [15:0] max_phase_current_i;
    reg  [15:0] residual1_current_i;
    reg  [15:0] residual2_current_i;
    reg  [2:0]  light_req;
    reg         slow;
    wire [31:0] rdata_o;
    wire        light_sensor_one_i;
    wire        light_sensor_two_i;
    wire        peer_light_input_i;
    wire        peer_light_output_o;
    wire [2:0]  stage_start_o;
    wire [2:0]  stage_trip_o;
    wire        delayed_light_o;
    wire        peer_input_state_o;
    integer     n_mismatch = 0;
    integer     tests_run = 0;
    // Peer output per route code with only sensor one lit and a trip.
    localparam [7:0] ROUTE_MAP = 8'h4A;

    afps_light_src src_u (.clk_i, .light_req_i(light_req), .slow_i(slow),
        .light_sensor_one_o(light_sensor_one_i),
        .light_sensor_two_o(light_sensor_two_i),
        .peer_light_input_o(peer_light_input_i));
    afps_top dut_u (.clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .light_sensor_one_i, .light_sensor_two_i,
        .peer_light_input_i, .max_phase_current_i, .residual1_current_i,
        .residual2_current_i, .peer_light_output_o, .stage_start_o,
        .stage_trip_o, .delayed_light_o, .peer_input_state_o);

    task chk_reg(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: reg %h, want %h", $time, got, exp);
        end
    endtask
    task chk_out(input [2:0] got, input [2:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: pins %b, want %b", $time, got, exp);
        end
    endtask
    // Bus cycles leave one idle edge after each strobe.
    task bus_wr(input [7:0] a, input [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task bus_rd(input [7:0] a, input [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk_reg(rdata_o, exp);
    endtask
    // Six edges cover the source lag and the two-flop synchroniser.
    task set_light(input [2:0] p);
        @(posedge clk_i);
        light_req <= p;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
    task t_lock;
        bus_rd(`AFPS_REG_CTRL, 32'h4);
        bus_rd(`AFPS_REG_DELAY, 32'h1);
        bus_rd(8'h44, 32'h0);
        bus_wr(`AFPS_REG_PICKUP_PH, 32'h0300);
        bus_rd(`AFPS_REG_PICKUP_PH, 32'h0100);
        bus_wr(`AFPS_REG_PASSWORD, `AFPS_PASSWORD);
        bus_wr(`AFPS_REG_PICKUP_PH, 32'h0200);
        bus_rd(`AFPS_REG_PICKUP_PH, 32'h0200);
        bus_wr(`AFPS_REG_DELAY, 32'h0);
        bus_rd(`AFPS_REG_DELAY, 32'h1);
        bus_wr(`AFPS_REG_DELAY, 32'hF);
        bus_rd(`AFPS_REG_DELAY, 32'hF);
    endtask
    task t_sel;
        integer c, p, n_s;
        begin
            n_s = 0;
            for (c = 0; c < 8; c = c + 1) begin
                bus_wr(`AFPS_REG_SRC_SEL, c | c << 3 | c << 6 | c << 16);
                for (p = 1; p < 8; p = p + 1) begin
                    set_light(p[2:0]);
                    chk_out(stage_start_o, {3{|(c & p)}});
                    chk_out(stage_trip_o, 3'h0);
                    chk_out(peer_input_state_o, p[2]);
                    set_light(3'h0);
                    n_s = n_s + ((c & p) ? 1 : 0);
                end
            end
            bus_rd(`AFPS_REG_SRC_SEL, 32'h0007_01FF);
            bus_rd(`AFPS_REG_LIGHT_CNT, 32'd56);
            bus_rd(`AFPS_REG_START_CNT0, n_s);
        end
    endtask
    task t_trip;
        bus_wr(`AFPS_REG_SRC_SEL, 32'h0000_0111);
        max_phase_current_i <= 16'h0200;
        residual1_current_i <= 16'h0101;
        residual2_current_i <= 16'h0100;
        set_light(3'h7);
        chk_out(stage_trip_o, 3'h2);
        max_phase_current_i <= 16'h0201;
        set_light(3'h7);
        chk_out(stage_trip_o, 3'h3);
        bus_rd(`AFPS_REG_TRIP_CNT0, 32'h1);
        bus_rd(`AFPS_REG_TRIP_CNT0 + 8'h4, 32'h1);
        bus_rd(`AFPS_REG_TRIP_CNT0 + 8'h8, 32'h0);
    endtask
    task t_route;
        integer r;
        begin
            set_light(3'h1);
            for (r = 0; r < 8; r = r + 1) begin
                bus_wr(`AFPS_REG_ROUTE, r);
                repeat (3) @(posedge clk_i);
                #1;
                chk_out(peer_light_output_o, ROUTE_MAP[r]);
            end
            // Freeze with a slow source: the dark must wait for the enable.
            ce_i <= 1'b0;
            slow <= 1'b1;
            set_light(3'h0);
            chk_out(stage_start_o, 3'h1);
            ce_i <= 1'b1;
            set_light(3'h0);
            chk_out(stage_start_o, 3'h0);
        end
    endtask
    task t_clear;
        bus_wr(`AFPS_REG_CTRL, 32'h2);
        bus_rd(`AFPS_REG_LIGHT_CNT, 32'h0);
        bus_rd(`AFPS_REG_TRIP_CNT0, 32'h0);
        bus_wr(`AFPS_REG_FORCE_STAT, 32'h77);
        bus_rd(`AFPS_REG_STATUS, 32'h0);
        bus_rd(`AFPS_REG_FORCE_STAT, 32'h0);
        // Live: start and trip on stage 0; force start only.
        set_light(3'h1);
        bus_wr(`AFPS_REG_CTRL, 32'h1);
        bus_wr(`AFPS_REG_FORCE_STAT, 32'h01);
        bus_rd(`AFPS_REG_STATUS, 32'h101);
        bus_wr(`AFPS_REG_CTRL, 32'h4);
        bus_rd(`AFPS_REG_STATUS, 32'h111);
        set_light(3'h0);
        bus_wr(`AFPS_REG_PICKUP_PH, 32'h0300);
        bus_rd(`AFPS_REG_PICKUP_PH, 32'h0200);
    endtask
    task conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Watchdog well beyond the thousand or so cycles the tests take.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch = n_mismatch + 1;
        conclude;
    end
    initial begin
        {rst_i, ce_i, wr_i, rd_i, slow} = 5'h18;
        {addr_i, wdata_i, light_req} = 43'h0;
        {max_phase_current_i, residual1_current_i} = 32'h0;
        residual2_current_i = 16'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_lock;
        t_sel;
        t_trip;
        t_route;
        t_clear;
        conclude;
    end
endmodule
